// ### io_port_consts.vh
`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH
// register addresses (4-bit port address space)
`define ADDR_PORT_A_DATA      4'h5
`define ADDR_PORT_B_DATA      4'h6
`define ADDR_INT_STATUS       4'h7
`define ADDR_PORT_A_DIR       4'h8
`define ADDR_PORT_B_DIR       4'h9
`define ADDR_PULL_DOWN        4'hB
`define ADDR_OPEN_DRAIN       4'hC
`define ADDR_PULL_HIGH        4'hD
`define ADDR_WDT_CTRL         4'hE
`define ADDR_INT_MASK         4'hF
`define ADDR_GLOBAL_IE        4'h1
// field positions
`define BIT_ROC               4
`define BIT_EIS               6
`define BIT_WATCHDOG_ENABLE              7
`define BIT_TIMER_IRQ         0
`define BIT_CHANGE_IRQ        1
`define BIT_EXT_IRQ           2
// reset values
`define RST_OPEN_DRAIN        8'h00
`define RST_PULL_HIGH         8'hFF
`define RST_PULL_DOWN         8'hFF
`define RST_DIR_A             4'hF
`define RST_DIR_B             8'hFF
`define RST_WDT_CTRL          8'h80
`define RST_INT_MASK          3'h0
`endif

// ### pin_sync.v
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  // first stage is read only by the second
  reg [WIDTH-1:0] stage1;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### io_port_pin_and_irq_control.v
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "io_port_consts.vh"
module io_port_pin_and_irq_control #(
  parameter [9:0] IRQ_VECTOR = 10'h008
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [7:0]  regRdData,
  input  wire        enable_interrupts_instr,
  input  wire        disable_interrupts_instr,
  input  wire        sleep_instr,
  input  wire        timerOverflow,
  input  wire [3:0]  portAIn,
  output wire [3:0]  portAOut,
  output wire [3:0]  portAOe,
  output wire [2:0]  portAPullDown,
  output wire [1:0]  portAOptionSense,
  input  wire [7:0]  portBIn,
  output wire [7:0]  portBOut,
  output wire [7:0]  portBOe,
  output wire [7:0]  portBPullHigh,
  output wire [3:0]  portBPullDown,
  output wire        watchdog_enable,
  output wire        irqRequest,
  output wire        wakeUp,
  output wire        asleep,
  output wire [9:0]  irqVector
);
  reg  [3:0] portADataOut;
  reg  [7:0] portBDataOut;
  reg  [3:0] portADir;
  reg  [7:0] portBDir;
  reg  [7:0] pullDownCtl;
  reg  [7:0] open_drain_enable;
  reg  [7:0] pull_high_disable;
  reg        resistor_option_enable;
  reg        interrupt_pin_select;
  reg        watchdogEn;
  reg  [2:0] interrupt_enable_mask;
  reg  [2:0] interrupt_status;
  reg        globalIe;
  reg        sleeping;
  reg  [7:0] portBLatched;
  reg        extPinLast;
  wire [3:0] portASync;
  wire [7:0] portBSync;
  wire       wrHit;
  wire       rdHit;
  wire [7:0] portBView;
  wire       portChange;
  wire       extFall;
  wire [2:0] eventSet;
  wire [2:0] pending;
  wire [2:0] clearMask;

  pin_sync #(.WIDTH(4)) syncA (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (portAIn),
    .syncOut  (portASync)
  );
  pin_sync #(.WIDTH(8)) syncB (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (portBIn),
    .syncOut  (portBSync)
  );

  assign wrHit = regWrite;
  assign rdHit = regRead;

  // pin0 reads the interrupt pin level when selected; same pad either way
  assign portBView = portBSync;

  // pin driving, per pin
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gen_portb
      // open-drain: only drive while the data bit is low
      assign portBOe[i] = ~portBDir[i] & ~(interrupt_pin_select && i == 0)
                          & ~(open_drain_enable[i] & portBDataOut[i]);
      assign portBOut[i] = portBDataOut[i];
      assign portBPullHigh[i] = ~pull_high_disable[i];
    end
    for (i = 0; i < 4; i = i + 1) begin : gen_porta
      assign portAOe[i]  = ~portADir[i];
      assign portAOut[i] = portADataOut[i];
    end
  endgenerate

  // pull-down control bits are active low like pull-high
  assign portAPullDown = ~pullDownCtl[2:0];
  assign portBPullDown = ~pullDownCtl[7:4];
  assign portAOptionSense = {2{resistor_option_enable}};

  assign watchdog_enable = watchdogEn;

  // change against the value captured at the last port B read
  assign portChange = |(portBSync ^ portBLatched);
  // external pin path blocked unless selected
  assign extFall = interrupt_pin_select & extPinLast & ~portBSync[0];
  assign eventSet = {extFall, portChange, timerOverflow};
  assign pending = interrupt_status & interrupt_enable_mask;
  assign irqRequest = globalIe & (|pending) & ~sleeping;
  // change wake-up fires regardless of the global enable
  assign wakeUp = sleeping & pending[`BIT_CHANGE_IRQ];
  assign asleep = sleeping;
  // vector is always the fixed IRQ_VECTOR, whatever the global enable
  assign irqVector = IRQ_VECTOR;

  // one decode per register keeps each enable easy to follow
  wire       wrPortAData;
  wire       wrPortBData;
  wire       wrPortADir;
  wire       wrPortBDir;
  wire       wrPullDown;
  wire       wrOpenDrain;
  wire       wrPullHigh;
  wire       wrWdtCtrl;
  wire       wrIntMask;
  wire       wrIntStatus;
  wire       wrGlobalIe;
  wire       rdPortB;
  wire [7:0] wdtCtrlRst;

  assign wrPortAData = wrHit && (regAddr == `ADDR_PORT_A_DATA);
  assign wrPortBData = wrHit && (regAddr == `ADDR_PORT_B_DATA);
  assign wrPortADir  = wrHit && (regAddr == `ADDR_PORT_A_DIR);
  assign wrPortBDir  = wrHit && (regAddr == `ADDR_PORT_B_DIR);
  assign wrPullDown  = wrHit && (regAddr == `ADDR_PULL_DOWN);
  assign wrOpenDrain = wrHit && (regAddr == `ADDR_OPEN_DRAIN);
  assign wrPullHigh  = wrHit && (regAddr == `ADDR_PULL_HIGH);
  assign wrWdtCtrl   = wrHit && (regAddr == `ADDR_WDT_CTRL);
  assign wrIntMask   = wrHit && (regAddr == `ADDR_INT_MASK);
  assign wrIntStatus = wrHit && (regAddr == `ADDR_INT_STATUS);
  assign wrGlobalIe  = wrHit && (regAddr == `ADDR_GLOBAL_IE);
  assign rdPortB     = rdHit && (regAddr == `ADDR_PORT_B_DATA);
  assign wdtCtrlRst  = `RST_WDT_CTRL;

  // writing a 0 clears a flag; flags cannot be set by software
  assign clearMask = wrIntStatus ? regWrData[2:0] : 3'h7;

  // only four pins exist on port A
  always @(posedge core_clk) begin
    if (sys_rst) begin
      portADataOut <= 4'h0;
    end else if (wrPortAData) begin
      portADataOut <= regWrData[3:0];
    end
  end

  // open-drain pins use the data bit only as the low drive
  always @(posedge core_clk) begin
    if (sys_rst) begin
      portBDataOut <= 8'h00;
    end else if (wrPortBData) begin
      portBDataOut <= regWrData;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      portADir <= `RST_DIR_A;
    end else if (wrPortADir) begin
      portADir <= regWrData[3:0];
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      portBDir <= `RST_DIR_B;
    end else if (wrPortBDir) begin
      portBDir <= regWrData;
    end
  end

  // bit 3 has no pin behind it, so writes clear it; reset sets it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pullDownCtl <= `RST_PULL_DOWN;
    end else if (wrPullDown) begin
      pullDownCtl <= regWrData & 8'hF7;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      open_drain_enable <= `RST_OPEN_DRAIN;
    end else if (wrOpenDrain) begin
      open_drain_enable <= regWrData;
    end
  end

  // pull-high control is active low
  always @(posedge core_clk) begin
    if (sys_rst) begin
      pull_high_disable <= `RST_PULL_HIGH;
    end else if (wrPullHigh) begin
      pull_high_disable <= regWrData;
    end
  end

  // reset level comes from the full register image
  always @(posedge core_clk) begin
    if (sys_rst) begin
      watchdogEn             <= wdtCtrlRst[`BIT_WATCHDOG_ENABLE];
      interrupt_pin_select   <= 1'b0;
      resistor_option_enable <= 1'b0;
    end else if (wrWdtCtrl) begin
      watchdogEn             <= regWrData[`BIT_WATCHDOG_ENABLE];
      interrupt_pin_select   <= regWrData[`BIT_EIS];
      resistor_option_enable <= regWrData[`BIT_ROC];
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      interrupt_enable_mask <= `RST_INT_MASK;
    end else if (wrIntMask) begin
      interrupt_enable_mask <= regWrData[2:0];
    end
  end

  // an instruction pulse outranks a register write in the same cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      globalIe <= 1'b0;
    end else if (enable_interrupts_instr) begin
      globalIe <= 1'b1;
    end else if (disable_interrupts_instr) begin
      globalIe <= 1'b0;
    end else if (wrGlobalIe) begin
      globalIe <= regWrData[0];
    end
  end

  // set beats clear in the same cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      interrupt_status <= 3'h0;
    end else begin
      interrupt_status <= (interrupt_status & clearMask) | eventSet;
    end
  end

  // sleep entry outranks a wake in the same cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sleeping <= 1'b0;
    end else if (sleep_instr) begin
      sleeping <= 1'b1;
    end else if (wakeUp) begin
      sleeping <= 1'b0;
    end
  end

  // reading port B re-arms change detection
  always @(posedge core_clk) begin
    if (sys_rst) begin
      portBLatched <= 8'h00;
    end else if (rdPortB) begin
      portBLatched <= portBSync;
    end
  end

  // idles high, so a pin low at release meets the fall condition; select clear at reset blocks it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      extPinLast <= 1'b1;
    end else begin
      extPinLast <= portBSync[0];
    end
  end

  // unmapped addresses and unused bits read as zero, except pull-down bit 3, which reads 1 from reset until the first write
  reg  [7:0] next_rdData;
  always @* begin
    next_rdData = 8'h00;
    if (rdHit) begin
      case (regAddr)
        `ADDR_PORT_A_DATA: next_rdData = {4'h0,
          resistor_option_enable ? {portASync[3:2], portASync[1:0]}
                                 : portASync};
        `ADDR_PORT_B_DATA: next_rdData = portBView;
        `ADDR_INT_STATUS:  next_rdData = {5'h00, pending};
        `ADDR_PORT_A_DIR:  next_rdData = {4'h0, portADir};
        `ADDR_PORT_B_DIR:  next_rdData = portBDir;
        `ADDR_PULL_DOWN:   next_rdData = pullDownCtl;
        `ADDR_OPEN_DRAIN:  next_rdData = open_drain_enable;
        `ADDR_PULL_HIGH:   next_rdData = pull_high_disable;
        `ADDR_WDT_CTRL:    next_rdData = {watchdogEn, interrupt_pin_select,
                                          1'b0, resistor_option_enable,
                                          4'h0};
        `ADDR_INT_MASK:    next_rdData = {5'h00, interrupt_enable_mask};
        `ADDR_GLOBAL_IE:   next_rdData = {7'h00, globalIe};
        default:           next_rdData = 8'h00;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= next_rdData;
    end
  end
endmodule
`default_nettype wire

// ### io_port_props.sv
`timescale 1ns/100ps
`default_nettype none
module io_port_props (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] portBPullHigh,
  input wire logic [7:0] portBOe,
  input wire logic [1:0] portAOptionSense,
  input wire logic       watchdog_enable,
  input wire logic [9:0] irqVector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_od_readback: assert property (
    regWrite && regAddr == 4'hC ##2 regRead && regAddr == 4'hC
    |=> regRdData == $past(regWrData, 3)) else $error("od readback");
  chk_wdt_bit: assert property (
    regWrite && regAddr == 4'hE
    |=> watchdog_enable == $past(regWrData[7])) else $error("wdt bit");
  chk_pull_map: assert property (
    regWrite && regAddr == 4'hD
    |=> portBPullHigh == ~$past(regWrData)) else $error("pull-high");
  chk_option_sense: assert property (
    regWrite && regAddr == 4'hE
    |=> portAOptionSense == {2{$past(regWrData[4])}})
    else $error("option sense");
  chk_wdt_unused: assert property (
    regRead && regAddr == 4'hE |=> (regRdData & 8'h2F) == 8'h00)
    else $error("wdt unused bits");
  chk_mask_unused: assert property (
    regRead && regAddr == 4'hF |=> regRdData[7:3] == 5'h00)
    else $error("mask unused bits");
  chk_reset_values: assert property (
    $fell(sys_rst) |-> watchdog_enable && portBPullHigh == 8'h00
    && portBOe == 8'h00) else $error("reset values");
  chk_vector_fixed: assert property (
    irqVector == 10'h008) else $error("vector");
  cover property (regWrite && regAddr == 4'hC);
  cover property (regWrite && regAddr == 4'hE && regWrData[4]);
  cover property ($fell(sys_rst));
endmodule
`default_nettype wire

// ### pin_board.sv
`timescale 1ns/100ps
`default_nettype none
module pin_board (
  input  wire logic       core_clk,
  input  wire logic [7:0] bOut,
  input  wire logic [7:0] bOe,
  input  wire logic [7:0] bPh,
  input  wire logic [7:0] extB,
  input  wire logic [7:0] extEn,
  input  wire logic [3:0] bPd,
  input  wire logic [3:0] aOut,
  input  wire logic [3:0] aOe,
  input  wire logic [1:0] aSen,
  input  wire logic [1:0] fitted,
  output wire logic [7:0] bIn,
  output wire logic [3:0] aIn
);
  // a floating pin toggles so a stale level never passes for a real one
  logic [7:0] flt = 8'h5A;
  always @(posedge core_clk) flt <= ~flt;
  assign bIn = bOe & bOut | ~bOe & (extEn & extB
               | ~extEn & (bPh | ~{4'h0, bPd} & flt));
  // fitted resistor pulls the sensed pin to ground
  assign aIn = aOe & aOut | ~aOe & {2'b00, aSen & ~fitted};
endmodule
`default_nettype wire

// ### io_port_pin_and_irq_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module io_port_pin_and_irq_control_tb_top;
  logic        core_clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0;
  logic        regRead = 1'b0, timerOverflow = 1'b0, sleep_instr = 1'b0;
  logic        enable_interrupts_instr = 1'b0, seen;
  logic        disable_interrupts_instr = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWrData = 8'h00, extB = 8'hFF, extEn = 8'hFF, r;
  logic [1:0]  fitted = 2'b01;
  logic [31:0] seed = 32'h02368B81;
  wire  [7:0]  regRdData, portBIn, portBOut, portBOe, portBPullHigh;
  wire  [3:0]  portAIn, portAOut, portAOe, portBPullDown;
  wire  [2:0]  portAPullDown;
  wire  [1:0]  portAOptionSense;
  wire  [9:0]  irqVector;
  wire         watchdog_enable, irqRequest, wakeUp, asleep;
  int          mismatches = 0, n_tests = 0;
  always #5 core_clk = ~core_clk;
  io_port_pin_and_irq_control dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData),
    .enable_interrupts_instr(enable_interrupts_instr),
    .disable_interrupts_instr(disable_interrupts_instr),
    .sleep_instr(sleep_instr), .timerOverflow(timerOverflow),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
    .portAPullDown(portAPullDown), .portAOptionSense(portAOptionSense),
    .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
    .portBPullHigh(portBPullHigh), .portBPullDown(portBPullDown),
    .watchdog_enable(watchdog_enable), .irqRequest(irqRequest),
    .wakeUp(wakeUp), .asleep(asleep), .irqVector(irqVector));
  pin_board brd (.core_clk(core_clk), .bOut(portBOut), .bOe(portBOe),
    .bPh(portBPullHigh), .extB(extB), .extEn(extEn), .bPd(portBPullDown),
    .aOut(portAOut), .aOe(portAOe), .aSen(portAOptionSense),
    .fitted(fitted), .bIn(portBIn), .aIn(portAIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xorshift = x ^ (x << 5);
  endfunction
  // drive enable of a port B pin: output, and not an open-drain high
  function automatic logic [7:0] exp_oe(input logic [7:0] od,
                                        input logic [7:0] data,
                                        input logic [7:0] dir);
    exp_oe = ~dir & ~(od & data);
  endfunction
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
    @(posedge core_clk) regWrite <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk) {regAddr, regRead} <= {a, 1'b1};
    @(posedge core_clk) regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(4'hC, 8'h00);
    rdc(4'hD, 8'hFF);
    rdc(4'hE, 8'h80);
    rdc(4'hF, 8'h00);
    chk({1'b0, portAPullDown, portBPullDown}, 8'h00);
    $display("reset test done");
    repeat (6) begin
      seed = xorshift(seed);
      r = seed[7:0];
      wrr(4'hC, r);
      rdc(4'hC, r);
      wrr(4'hD, r);
      chk(portBPullHigh, ~r);
      wrr(4'hE, r & 8'hBF);
      rdc(4'hE, r & 8'h90);
      chk({7'h0, watchdog_enable}, {7'h0, r[7]});
      wrr(4'hF, r);
      rdc(4'hF, r & 8'h07);
      wrr(4'h9, 8'h00);
      wrr(4'h6, 8'hA5);
      chk(portBOe, exp_oe(r, 8'hA5, 8'h00));
    end
    $display("register test done");
    wrr(4'hB, 8'h00);
    chk({1'b0, portAPullDown, portBPullDown}, 8'h7F);
    wrr(4'hE, 8'h10);
    repeat (2) @(posedge core_clk);
    rdc(4'h5, 8'h02);
    wrr(4'hE, 8'h40);
    wrr(4'h9, 8'h01);
    chk({7'h0, portBOe[0]}, 8'h00);
    wrr(4'hF, 8'h04);
    wrr(4'h7, 8'h00);
    extB <= 8'hFE;
    repeat (4) @(posedge core_clk);
    rdc(4'h7, 8'h04);
    wrr(4'h9, 8'hFF);
    repeat (2) @(posedge core_clk);
    rdc(4'h6, 8'hFE);
    wrr(4'h7, 8'h00);
    wrr(4'hF, 8'h02);
    rdc(4'h7, 8'h00);
    chk({7'h0, watchdog_enable}, 8'h00);
    @(posedge core_clk) enable_interrupts_instr <= 1'b1;
    @(posedge core_clk) {enable_interrupts_instr, sleep_instr} <= 2'b01;
    @(posedge core_clk) {sleep_instr, extB} <= {1'b0, 8'h7E};
    #1 chk({7'h0, asleep}, 8'h01);
    seen = 1'b0;
    repeat (10) @(negedge core_clk) seen |= wakeUp;
    chk({7'h0, seen}, 8'h01);
    rdc(4'h7, 8'h02);
    rdc(4'h6, 8'h7E);
    wrr(4'h7, 8'h00);
    rdc(4'h7, 8'h00);
    wrr(4'hF, 8'h01);
    @(posedge core_clk) timerOverflow <= 1'b1;
    @(posedge core_clk) timerOverflow <= 1'b0;
    #1 chk({6'h0, irqRequest, asleep}, 8'h02);
    rdc(4'h7, 8'h01);
    @(posedge core_clk) disable_interrupts_instr <= 1'b1;
    @(posedge core_clk) disable_interrupts_instr <= 1'b0;
    #1 chk({7'h0, irqRequest}, 8'h00);
    rdc(4'h1, 8'h00);
    wrr(4'h8, 8'h00);
    wrr(4'h5, 8'h0A);
    chk({portAOe, portAOut}, 8'hFA);
    $display("pin test done");
    final_report();
  end
  initial begin
    #60000;
    mismatches++;
    final_report();
  end
endmodule
bind io_port_pin_and_irq_control io_port_props chk (.*);
`default_nettype wire
